// ==== rtl/gst_pkg.sv ====
package gst_pkg;

  // byte addresses of the word registers
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_STATUS      = 8'h08;
  localparam logic [7:0] ADDR_MASK        = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_PINS        = 8'h18;

  // timer_control field positions
  localparam int CTL_ON      = 0;
  localparam int CTL_CS      = 1;
  localparam int CTL_ASYNC   = 2;
  localparam int CTL_OSCEN   = 3;
  localparam int CTL_PS_LO   = 4;
  localparam int CTL_PS_HI   = 5;
  localparam int CTL_GE      = 6;
  localparam int CTL_WIDTH   = 7;

  // status / mask bit and irq_control bits
  localparam int STAT_OVF    = 0;
  localparam int IRQC_PERIPH = 0;
  localparam int IRQC_GLOBAL = 1;

  // reset values and the count maximum
  localparam logic [CTL_WIDTH-1:0] CTL_RESET   = 7'h00;
  localparam logic [15:0]          COUNT_RESET = 16'h0000;
  localparam logic [15:0]          COUNT_MAX   = 16'hffff;

  // one instruction cycle is four system clocks
  localparam int         OSC_PER_INSTR = 4;
  localparam logic [1:0] QPHASE_LAST   = 2'(OSC_PER_INSTR - 1);

  // ahb transfer type bit that marks NONSEQ/SEQ
  localparam int HTRANS_ACTIVE = 1;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } gst_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } gst_ahb_rsp_s;

  typedef struct packed {
    logic [15:0]          count;
    logic [2:0]           pre;
    logic [CTL_WIDTH-1:0] ctl;
    logic                 flag;
    logic                 mask;
    logic [1:0]           irqc;
    logic                 armed;
    logic                 src_prev;
    logic [1:0]           qphase;
    logic                 wr_pend;
    logic [7:0]           waddr;
    logic [31:0]          rdata;
  } gst_state_s;

endpackage : gst_pkg

// ==== rtl/gst_sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
module gst_sync2 (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output var  logic level_out
);
  logic stage1_q;
  logic stage2_q;

  // two flops; only the second stage is visible to the outside
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= level_in;
      stage2_q <= stage1_q;
    end
  end

  assign level_out = stage2_q;
endmodule : gst_sync2
`default_nettype wire

// ==== rtl/gst_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module gst_timer (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire gst_pkg::gst_ahb_req_s ahb_req_in,
  input  wire logic                 hready_in,
  output var  gst_pkg::gst_ahb_rsp_s ahb_rsp_out,
  input  wire logic                 external_count_clock_in,
  input  wire logic                 crystal_clock_in,
  input  wire logic                 gate_input_n_in,
  input  wire logic                 sleep_in,
  input  wire logic                 internal_oscillator_no_clock_output_in,
  input  wire logic [1:0]           pin_direction_in,
  input  wire logic [1:0]           port_pin_in,
  output var  logic                 irq_out,
  output var  logic                 wake_out,
  output var  logic                 crystal_osc_on_out,
  output var  logic                 pin_force_input_out
);
  import gst_pkg::*;

  gst_state_s s_q;
  gst_state_s s_d;

  logic       synced_level;
  logic       osc_eff;
  logic       ext_sel;
  logic       async_mode;
  logic       src_raw;
  logic       src_level;
  logic       run;
  logic       src_tick;
  logic       inc;
  logic       ovf;
  logic       addr_valid;
  logic       cnt_write;
  logic       flag_clear;
  logic [2:0] pre_limit;

  // word-aligned register match, shared by read and write decoding
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction : reg_hit

  // sync path for the count source; raw path bypasses it in async mode
  gst_sync2 u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .level_in   (src_raw),
    .level_out  (synced_level)
  );

  // mode decode from the control register
  always_comb begin
    osc_eff    = s_q.ctl[CTL_OSCEN] & internal_oscillator_no_clock_output_in;
    ext_sel    = s_q.ctl[CTL_CS];
    async_mode = ext_sel & s_q.ctl[CTL_ASYNC];
    src_raw    = osc_eff ? crystal_clock_in : external_count_clock_in;
    src_level  = async_mode ? src_raw : synced_level;
    // gate only matters once the on bit is set; sleep stops all but async
    run        = s_q.ctl[CTL_ON] & (~s_q.ctl[CTL_GE] | ~gate_input_n_in)
                 & (~sleep_in | async_mode);
    pre_limit  = 3'((4'h1 << s_q.ctl[CTL_PS_HI:CTL_PS_LO]) - 4'h1);
  end

  // next-state logic: counting, bus writes and read data
  always_comb begin
    s_d        = s_q;
    src_tick   = 1'b0;
    inc        = 1'b0;
    ovf        = 1'b0;
    cnt_write  = 1'b0;
    flag_clear = 1'b0;
    addr_valid = ahb_req_in.hsel & ahb_req_in.htrans[HTRANS_ACTIVE] & hready_in;

    // free-running instruction-cycle phase
    s_d.qphase   = 2'(s_q.qphase + 2'h1);
    s_d.src_prev = src_level;

    // a falling edge must be seen after enabling before a rising edge counts
    if (!run || !ext_sel) begin
      s_d.armed = 1'b0;
    end else if (!src_level && s_q.src_prev) begin
      s_d.armed = 1'b1;
    end

    if (ext_sel) begin
      src_tick = src_level & ~s_q.src_prev & s_q.armed;
    end else begin
      src_tick = (s_q.qphase == QPHASE_LAST);
    end

    if (run && src_tick) begin
      if (s_q.pre == pre_limit) begin
        s_d.pre = 3'h0;
        inc     = 1'b1;
      end else begin
        s_d.pre = 3'(s_q.pre + 3'h1);
      end
    end

    if (inc) begin
      s_d.count = 16'(s_q.count + 16'h0001);
      ovf       = (s_q.count == COUNT_MAX);
    end

    // write data phase; a count write overrides a colliding increment only in the byte it writes
    if (s_q.wr_pend) begin
      if (reg_hit(s_q.waddr, ADDR_COUNT_LOW)) begin
        s_d.count[7:0] = ahb_req_in.hwdata[7:0];
        cnt_write      = 1'b1;
      end
      if (reg_hit(s_q.waddr, ADDR_COUNT_HIGH)) begin
        s_d.count[15:8] = ahb_req_in.hwdata[7:0];
        cnt_write       = 1'b1;
      end
      if (reg_hit(s_q.waddr, ADDR_CONTROL)) begin
        s_d.ctl = ahb_req_in.hwdata[CTL_WIDTH-1:0];
      end
      if (reg_hit(s_q.waddr, ADDR_STATUS)) begin
        flag_clear = ahb_req_in.hwdata[STAT_OVF];
      end
      if (reg_hit(s_q.waddr, ADDR_MASK)) begin
        s_d.mask = ahb_req_in.hwdata[STAT_OVF];
      end
      if (reg_hit(s_q.waddr, ADDR_IRQ_CONTROL)) begin
        s_d.irqc = ahb_req_in.hwdata[1:0];
      end
    end
    if (cnt_write) begin
      s_d.pre = 3'h0;
    end

    // a new overflow wins over a clear in the same cycle
    s_d.flag = (s_q.flag & ~flag_clear) | ovf;

    // address phase: latch writes, fetch read data into a flop
    s_d.wr_pend = addr_valid & ahb_req_in.hwrite;
    if (addr_valid) begin
      s_d.waddr = ahb_req_in.haddr[7:0];
    end
    if (addr_valid && !ahb_req_in.hwrite) begin
      // count bytes come from flops, so a read is never torn mid-update
      s_d.rdata = 32'h0000_0000;
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_COUNT_LOW)) begin
        s_d.rdata[7:0] = s_q.count[7:0];
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_COUNT_HIGH)) begin
        s_d.rdata[7:0] = s_q.count[15:8];
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_STATUS)) begin
        s_d.rdata[STAT_OVF] = s_q.flag;
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_MASK)) begin
        s_d.rdata[STAT_OVF] = s_q.mask;
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_CONTROL)) begin
        s_d.rdata[CTL_WIDTH-1:0] = s_q.ctl;
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_IRQ_CONTROL)) begin
        s_d.rdata[1:0] = s_q.irqc;
      end
      if (reg_hit(ahb_req_in.haddr[7:0], ADDR_PINS)) begin
        // crystal owns both pins: directions read one, port bits zero
        s_d.rdata[1:0] = osc_eff ? 2'h3 : pin_direction_in;
        s_d.rdata[3:2] = osc_eff ? 2'h0 : port_pin_in;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{count: COUNT_RESET, pre: 3'h0, ctl: CTL_RESET, flag: 1'b0,
               mask: 1'b0, irqc: 2'h0, armed: 1'b0, src_prev: 1'b0,
               qphase: 2'h0, wr_pend: 1'b0, waddr: 8'h00, rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; zero-wait slave, always OKAY
  always_comb begin
    ahb_rsp_out.hrdata    = s_q.rdata;
    ahb_rsp_out.hreadyout = 1'b1;
    ahb_rsp_out.hresp     = 1'b0;
    irq_out     = s_q.flag & s_q.mask & s_q.irqc[IRQC_PERIPH]
                  & s_q.irqc[IRQC_GLOBAL];
    // wake does not need the global enable; that only decides vectoring
    wake_out    = sleep_in & s_q.flag & s_q.mask & s_q.irqc[IRQC_PERIPH];
    crystal_osc_on_out  = osc_eff;
    pin_force_input_out = osc_eff;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_wrap_sets_flag: assert property (inc && s_q.count == COUNT_MAX && !cnt_write
      |=> s_q.count == COUNT_RESET && s_q.flag) else $error("wrap did not clear count");
  a_off_holds_count: assert property (!s_q.ctl[CTL_ON] && !s_q.wr_pend
      |=> $stable(s_q.count)) else $error("count moved while off");
  a_gate_blocks_count: assert property (s_q.ctl[CTL_ON] && s_q.ctl[CTL_GE]
      && gate_input_n_in && !s_q.wr_pend |=> $stable(s_q.count))
      else $error("count moved while gated");
  a_write_clears_pre: assert property (cnt_write |=> s_q.pre == 3'h0)
      else $error("prescaler not cleared by count write");
  a_internal_rate: assert property (inc && !ext_sel |-> s_q.qphase == QPHASE_LAST)
      else $error("internal increment off instruction boundary");
  a_edge_armed: assert property (inc && ext_sel |-> s_q.armed && !s_q.src_prev)
      else $error("external increment without prior falling edge");
  a_flag_sticky: assert property (s_q.flag && !flag_clear |=> s_q.flag)
      else $error("overflow flag dropped");
  a_irq_gating: assert property ($rose(s_q.flag) && s_q.mask && s_q.irqc == 2'h3
      |-> irq_out) else $error("enabled overflow raised no interrupt");
  a_sleep_stops: assert property (sleep_in && !async_mode && !s_q.wr_pend
      |=> $stable(s_q.count)) else $error("synchronous count moved in sleep");
  a_sleep_wake: assert property (sleep_in && $rose(s_q.flag) && s_q.mask
      && s_q.irqc[IRQC_PERIPH] |-> wake_out) else $error("overflow in sleep did not wake");
  a_prescale_div8: assert property (run && inc && s_q.ctl[CTL_PS_HI:CTL_PS_LO] == 2'h3
      |-> s_q.pre == 3'h7) else $error("divide by eight wrong");
endmodule : gst_timer
`default_nettype wire

// ==== dv/gst_ext_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// far-side clock source: one waveform feeds both the external pin and the crystal line
module gst_ext_model (
  input  wire logic clk_sys_in,
  output var  logic ext_clk_out,
  output var  logic xtal_clk_out
);
  logic lvl     = 1'b0;
  logic pin_off = 1'b0;

  // the clock stands still at its idle level between bursts; a muted pin
  // leaves the crystal line alone carrying edges, so the source mux shows
  assign ext_clk_out  = lvl & ~pin_off;
  assign xtal_clk_out = lvl;

  // park the line; only done while the timer is stopped
  task automatic set_idle(input logic v);
    @(posedge clk_sys_in);
    lvl <= v;
  endtask : set_idle

  // hold the external pin low whatever the waveform does
  task automatic mute_pin(input logic v);
    @(posedge clk_sys_in);
    pin_off <= v;
  endtask : mute_pin

  // each pulse leaves idle and comes back, so an idle-low burst starts on a rising edge
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk_sys_in);
      lvl <= ~lvl;
      repeat (half) @(posedge clk_sys_in);
      lvl <= ~lvl;
    end
  endtask : burst
endmodule : gst_ext_model
`default_nettype wire

// ==== dv/test_gated_sixteen_bit_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_gated_sixteen_bit_timer;
  import gst_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         rst_n_in   = 1'b0;
  gst_ahb_req_s req        = '0;
  gst_ahb_rsp_s rsp;
  logic         gate_n     = 1'b1;
  logic         sleep      = 1'b0;
  logic         internal_oscillator     = 1'b0;
  logic [1:0]   pdir       = 2'h0;
  logic [1:0]   pport      = 2'h0;
  logic         irq, wake, xon, pforce, ext, xtal, ge, a, idle, e;
  logic [1:0]   ps;
  logic [31:0]  rd, r;
  logic [31:0]  seed       = 32'h00006f92;
  int           n_fail     = 0;
  int           checks_done = 0;
  int           cyc        = 0;
  int           k, len, n;

  always #50 clk_sys_in = ~clk_sys_in;

  gst_timer u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ahb_req_in(req),
    .hready_in(rsp.hreadyout), .ahb_rsp_out(rsp), .external_count_clock_in(ext),
    .crystal_clock_in(xtal), .gate_input_n_in(gate_n), .sleep_in(sleep),
    .internal_oscillator_no_clock_output_in(internal_oscillator), .pin_direction_in(pdir), .port_pin_in(pport),
    .irq_out(irq), .wake_out(wake), .crystal_osc_on_out(xon), .pin_force_input_out(pforce));

  gst_ext_model u_src (.clk_sys_in(clk_sys_in), .ext_clk_out(ext), .xtal_clk_out(xtal));

  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // internal source: one tick per four clocks, one increment per prescale ticks
  function automatic logic [15:0] f_int(input logic [1:0] p, input logic blk, input int l);
    return blk ? 16'h0000 : 16'(l / (4 << p));
  endfunction : f_int

  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk32

  task automatic chk1(input logic g, input logic x);
    chk32({31'h0, g}, {31'h0, x});
  endtask : chk1

  // one single AHB transfer; the master never assumes the slave answers at once
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {24'h000000, ad};
    req.hwrite <= w;
    req.hsize <= 3'h2;
    // only the bench's hang guard ends a wait for hready
    do begin @(posedge clk_sys_in); end while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    do begin @(posedge clk_sys_in); end while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    bus(1'b0, ad, 32'h0);
    chk32(rd, x);
    chk1(rsp.hresp, 1'b0);
  endtask : rdc

  // count is always written with the timer stopped, as software should
  task automatic set_count(input logic [15:0] v);
    wr(ADDR_COUNT_LOW, {24'h0, v[7:0]});
    wr(ADDR_COUNT_HIGH, {24'h0, v[15:8]});
  endtask : set_count

  task automatic rd_count(input logic [15:0] x);
    logic [7:0] lo;
    bus(1'b0, ADDR_COUNT_LOW, 32'h0);
    lo = rd[7:0];
    bus(1'b0, ADDR_COUNT_HIGH, 32'h0);
    chk32({16'h0, rd[7:0], lo}, {16'h0, x});
  endtask : rd_count

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // hang guard, well above the under two thousand cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rdc(ADDR_CONTROL, 32'h0);
    rd_count(COUNT_RESET);
    rdc(ADDR_STATUS, 32'h0);
    rdc(8'h1c, 32'h0);
    // internal clock over every prescale code, gate drawn at random
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      ps = 2'(i);
      ge = r[0];
      gate_n <= r[1];
      k = 1 + int'(r[7:4] % 6);
      len = k * (4 << ps);
      set_count(16'h0000);
      wr(ADDR_CONTROL, {25'h0, ge, ps, 4'b0001});
      repeat (len - 2) @(posedge clk_sys_in);
      wr(ADDR_CONTROL, {25'h0, ge, ps, 4'b0000});
      repeat (7) @(posedge clk_sys_in);
      rd_count(f_int(ps, ge & gate_n, len));
    end
    // wrap and interrupt enables
    set_count(COUNT_MAX);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CONTROL, 32'h1);
    repeat (18) @(posedge clk_sys_in);
    wr(ADDR_CONTROL, 32'h0);
    rd_count(16'h0004);
    rdc(ADDR_STATUS, 32'h1);
    sleep <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MASK, {31'h0, m[0]});
      wr(ADDR_IRQ_CONTROL, {30'h0, m[2:1]});
      @(posedge clk_sys_in);
      chk1(irq, &m[2:0]);
      chk1(wake, m[0] & m[1]);
    end
    // a synchronous source stands still while asleep
    set_count(16'h0000);
    wr(ADDR_CONTROL, 32'h1);
    repeat (20) @(posedge clk_sys_in);
    wr(ADDR_CONTROL, 32'h0);
    rd_count(16'h0000);
    sleep <= 1'b0;
    rdc(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    rdc(ADDR_STATUS, 32'h0);
    chk1(irq, 1'b0);
    // external edges: sync and async, idle low and idle high
    for (int j = 0; j < 4; j++) begin
      a = j[0];
      idle = j[1];
      u_src.set_idle(idle);
      // start at the top so every burst wraps and raises the enabled interrupt
      set_count(COUNT_MAX);
      wr(ADDR_STATUS, 32'h1);
      sleep <= a;
      wr(ADDR_CONTROL, {29'h0, a, 2'b11});
      n = 2 + int'(rnd() % 5);
      u_src.burst(n, 6);
      repeat (10) @(posedge clk_sys_in);
      chk1(wake, a);
      chk1(irq, 1'b1);
      wr(ADDR_CONTROL, 32'h0);
      sleep <= 1'b0;
      rd_count(16'(COUNT_MAX + (idle ? n : n - 1)));
    end
    // crystal enable only takes effect with the internal oscillator
    for (int c = 0; c < 4; c++) begin
      r = rnd();
      pdir <= r[1:0];
      pport <= r[3:2];
      internal_oscillator <= c[0];
      wr(ADDR_CONTROL, {28'h0, c[1], 3'b000});
      @(posedge clk_sys_in);
      e = c[0] & c[1];
      chk1(xon, e);
      chk1(pforce, e);
      rdc(ADDR_PINS, e ? 32'h3 : {28'h0, r[3:0]});
    end
    // crystal as count source: pin muted, crystal settles before the timer starts
    u_src.mute_pin(1'b1);
    u_src.set_idle(1'b1);
    internal_oscillator <= 1'b1;
    set_count(16'h0000);
    wr(ADDR_CONTROL, 32'h0000000a);
    repeat (40) @(posedge clk_sys_in);
    wr(ADDR_CONTROL, 32'h0000000b);
    u_src.burst(3, 6);
    repeat (10) @(posedge clk_sys_in);
    wr(ADDR_CONTROL, 32'h0);
    rd_count(16'h0003);
    end_sim();
  end
endmodule : test_gated_sixteen_bit_timer
`default_nettype wire
